// [rtl/bit_shift_pkg.sv]
// Constants, flag layout, bus map and operation codes for the bit, shift and flag unit
// Overview of operation
// [RULE1] Interrupt enable sets I, disable clears it
// [RULE2] Interrupt disable clears I only, one cycle
// [RULE3] Sign flag set/clear ops, one cycle
// [RULE4] Overflow flag set/clear ops, one cycle
// [RULE5] Transfer flag set/clear ops, one cycle
// [RULE6] Shift left, zero into bit 0, ZCNV
// [RULE7] Shift right, zero into bit 7, ZCNV
// [RULE8] Rotate left through carry, ZCNV updated
// [RULE9] Rotate right through carry, ZCNV updated
// [RULE10] Arithmetic shift right keeps bit 7, ZCNV
// [RULE11] Nibble swap, no flags touched
// [RULE12] Generic set/clear writes indexed status bit
// [RULE13] Bit store copies source bit into T
// [RULE14] Bit load copies T into destination bit
// [RULE15] Carry set/clear ops, one cycle
// [RULE16] Negative set/clear ops, one cycle
// [RULE17] Zero set/clear ops, one cycle
// [RULE18] Fixed flag indices; dedicated ops use generic path
package bit_shift_pkg;

   // Status register bit positions
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;

   // Values after reset
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // Wishbone byte addresses
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_RESULT = 8'h04;
   localparam logic [7:0] ADDR_OPCOUNT = 8'h08;

   // Operations handed over by the decoder
   typedef enum logic [4:0] {
      no_op,
      logical_shift_left_op,
      logical_shift_right_op,
      rotate_left_carry_op,
      rotate_right_carry_op,
      arith_shift_right_op,
      nibble_swap_op,
      generic_flag_set_op,
      generic_flag_clear_op,
      bit_to_transfer_flag_op,
      transfer_flag_to_bit_op,
      carry_set_op,
      carry_clear_op,
      negative_set_op,
      negative_clear_op,
      zero_set_op,
      zero_clear_op,
      irq_flag_set_op,
      irq_flag_clear_op,
      sign_flag_set_op,
      sign_flag_clear_op,
      overflow_flag_set_op,
      overflow_flag_clear_op,
      transfer_flag_set_op,
      transfer_flag_clear_op
   } op_e;

endpackage

// [rtl/shift_rotate_unit.sv]
// Combinational shifter: shifts, rotates through carry, nibble swap and their flags
`timescale 1ns/1ps
module shift_rotate_unit (
   // Operation and operands
   input wire bit_shift_pkg::op_e op_i,
   input wire logic [7:0] dest_i,
   input wire logic carry_i,
   // Result and flags
   output logic [7:0] result_o,
   output logic carry_o,
   output logic zero_o,
   output logic negative_o,
   output logic overflow_o,
   output logic flags_touched_o
);
   import bit_shift_pkg::*;

   // Shifted value and outgoing carry per operation
   always_comb begin
      result_o = dest_i;
      carry_o = carry_i;
      flags_touched_o = 1'b1;
      case (op_i)
         logical_shift_left_op: begin
            result_o = {dest_i[6:0], 1'b0}; // [RULE6]
            carry_o = dest_i[7];
         end
         logical_shift_right_op: begin
            result_o = {1'b0, dest_i[7:1]}; // [RULE7]
            carry_o = dest_i[0];
         end
         rotate_left_carry_op: begin
            result_o = {dest_i[6:0], carry_i}; // [RULE8]
            carry_o = dest_i[7];
         end
         rotate_right_carry_op: begin
            result_o = {carry_i, dest_i[7:1]}; // [RULE9]
            carry_o = dest_i[0];
         end
         arith_shift_right_op: begin
            result_o = {dest_i[7], dest_i[7:1]}; // [RULE10]
            carry_o = dest_i[0];
         end
         nibble_swap_op: begin
            // Swap leaves every flag alone
            result_o = {dest_i[3:0], dest_i[7:4]}; // [RULE11]
            flags_touched_o = 1'b0;
         end
         default: begin
            flags_touched_o = 1'b0;
         end
      endcase
   end

   // Flags derived from the shifted value; V is N xor new C
   always_comb begin
      zero_o = (result_o == 8'h00);
      negative_o = result_o[7];
      overflow_o = result_o[7] ^ carry_o;
   end

endmodule

// [rtl/bit_access_unit.sv]
// Per-bit write of one status flag and per-bit insert of T into a register
`timescale 1ns/1ps
module bit_access_unit (
   // Single status bit write
   input wire logic [7:0] status_i,
   input wire logic flag_wr_i,
   input wire logic [2:0] flag_idx_i,
   input wire logic flag_val_i,
   output logic [7:0] status_o,
   // Bit insert into destination
   input wire logic [7:0] dest_i,
   input wire logic [2:0] bit_idx_i,
   input wire logic transfer_i,
   output logic [7:0] inserted_o
);

   // One lane per bit; only the indexed lane changes
   genvar k;
   generate
      for (k = 0; k < 8; k++) begin : g_lane
         always_comb begin
            status_o[k] = (flag_wr_i && flag_idx_i == 3'(k)) ? flag_val_i : status_i[k];
            inserted_o[k] = (bit_idx_i == 3'(k)) ? transfer_i : dest_i[k];
         end
      end
   endgenerate

endmodule

// [rtl/bit_shift_flag_instruction_unit.sv]
// Execution unit for shift, rotate, swap, bit transfer and flag instructions
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module bit_shift_flag_instruction_unit (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Decoded operation from the instruction decoder
   input wire logic op_valid_i,
   input wire bit_shift_pkg::op_e op_i,
   input wire logic [7:0] dest_i,
   input wire logic [7:0] src_i,
   input wire logic [2:0] bit_idx_i,
   // Results back to the register file
   output logic [7:0] result_o,
   output logic result_we_o,
   output logic done_o,
   // Status register as seen by the core
   output logic [7:0] status_o,
   output logic irq_enable_o,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import bit_shift_pkg::*;

   // Architectural state; everything software reads over the bus
   // sits in these registers, the core outputs and bus reply are registered below
   logic [7:0] status; // Status flags
   logic [7:0] next_status;
   logic [7:0] last_result; // Last register result
   logic [7:0] next_last_result;
   logic [15:0] op_count; // Completed operations
   logic [15:0] next_op_count;

   // Registered outputs toward the core
   // Each holds one value per operation, no deeper pipelining
   logic [7:0] result;
   logic [7:0] next_result;
   logic result_we;
   logic next_result_we;
   logic done;
   logic next_done;

   // Bus slave state
   // Ack and read data are both registered, one cycle after request
   logic ack;
   logic next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;

   // Shifter outputs
   // Combinational, valid in the cycle the operation is presented
   logic [7:0] sh_result;
   logic sh_carry;
   logic sh_zero;
   logic sh_negative;
   logic sh_overflow;
   logic sh_touched;

   // Single-bit flag write request
   logic flag_wr;
   logic [2:0] flag_idx;
   logic flag_val;
   logic [7:0] base_status; // Status after any bus write
   logic [7:0] bit_status; // Status after the flag write
   logic [7:0] inserted; // Destination with T inserted

   // Bus request qualifiers
   logic bus_req;
   logic bus_wr;

   // Shift, rotate and swap datapath
   // Carry comes after any bus write so both paths see one value
   shift_rotate_unit u_shift (
      .op_i(op_i),
      .dest_i(dest_i),
      .carry_i(base_status[FLAG_C]),
      .result_o(sh_result),
      .carry_o(sh_carry),
      .zero_o(sh_zero),
      .negative_o(sh_negative),
      .overflow_o(sh_overflow),
      .flags_touched_o(sh_touched)
   );

   // Indexed flag write and bit insert
   // T for bit load is read before this cycle's own flag edit
   bit_access_unit u_bits (
      .status_i(base_status),
      .flag_wr_i(flag_wr),
      .flag_idx_i(flag_idx),
      .flag_val_i(flag_val),
      .status_o(bit_status),
      .dest_i(dest_i),
      .bit_idx_i(bit_idx_i),
      .transfer_i(base_status[FLAG_T]),
      .inserted_o(inserted)
   );

   // A bus request is answered once; ack low gates the second cycle.
   // The write itself commits at the edge where the master sees ack,
   // so a cycle abandoned before its answer leaves no trace
   always_comb begin
      bus_req = wb_cyc_i && wb_stb_i && !ack;
      bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack;
   end

   // Base status: a bus write lands first, an instruction then edits on top,
   // so hardware flag updates win over software in the same cycle;
   // only byte lane 0 carries the flags, upper lanes are ignored
   always_comb begin
      base_status = status;
      // Software value seen first; instruction edits override below
      if (bus_wr && wb_sel_i[0] && wb_adr_i == ADDR_STATUS) begin
         base_status = wb_dat_i[7:0];
      end
   end

   // Map each flag instruction onto one indexed write
   // One shared write port keeps every flag op a single-edge update
   always_comb begin
      flag_wr = op_valid_i;
      flag_idx = bit_idx_i;
      flag_val = 1'b0;
      case (op_i)
         generic_flag_set_op: begin
            // Index comes straight from the instruction operand
            flag_val = 1'b1; // [RULE12]
         end
         generic_flag_clear_op: begin
            flag_val = 1'b0; // [RULE12]
         end
         bit_to_transfer_flag_op: begin
            // Only T changes; the selected source bit is copied
            flag_idx = FLAG_T;
            flag_val = src_i[bit_idx_i]; // [RULE13]
         end
         carry_set_op, carry_clear_op: begin
            // Dedicated ops pin the index; the operand is ignored
            flag_idx = FLAG_C; // [RULE15] [RULE18]
            flag_val = (op_i == carry_set_op);
         end
         negative_set_op, negative_clear_op: begin
            // Set and clear share one branch, the code picks the value
            flag_idx = FLAG_N; // [RULE16] [RULE18]
            flag_val = (op_i == negative_set_op);
         end
         zero_set_op, zero_clear_op: begin
            flag_idx = FLAG_Z; // [RULE17] [RULE18]
            flag_val = (op_i == zero_set_op);
         end
         irq_flag_set_op: begin
            // Global enable; the core sees it on the next cycle
            flag_idx = FLAG_I;
            flag_val = 1'b1; // [RULE1]
         end
         irq_flag_clear_op: begin
            // Disable lands in the same edge as any other flag write
            flag_idx = FLAG_I;
            flag_val = 1'b0; // [RULE1] [RULE2]
         end
         sign_flag_set_op, sign_flag_clear_op: begin
            // Signed test flag, no arithmetic behind it here
            flag_idx = FLAG_S; // [RULE3] [RULE18]
            flag_val = (op_i == sign_flag_set_op);
         end
         overflow_flag_set_op, overflow_flag_clear_op: begin
            // Forced overflow value, independent of the shifter
            flag_idx = FLAG_V; // [RULE4] [RULE18]
            flag_val = (op_i == overflow_flag_set_op);
         end
         transfer_flag_set_op, transfer_flag_clear_op: begin
            // Same bit that bit store and bit load use
            flag_idx = FLAG_T; // [RULE5] [RULE18]
            flag_val = (op_i == transfer_flag_set_op);
         end
         default: begin
            // Shifts and bit load do not use the single-bit path
            flag_wr = 1'b0;
         end
      endcase
   end

   // Next status: shifts replace Z, C, N, V; all else via the bit path
   // S, H, T and I pass through a shift untouched
   always_comb begin
      next_status = bit_status;
      if (op_valid_i && sh_touched) begin
         next_status = base_status;
         next_status[FLAG_Z] = sh_zero; // [RULE6] [RULE7] [RULE8] [RULE9] [RULE10]
         next_status[FLAG_C] = sh_carry;
         next_status[FLAG_N] = sh_negative;
         next_status[FLAG_V] = sh_overflow;
      end
   end

   // Register result and write strobe for the register file
   // The strobe is a one-cycle pulse; the value holds so a late
   // reader of the bus result register still finds it
   always_comb begin
      next_result = result;
      next_result_we = 1'b0;
      next_done = op_valid_i && (op_i != no_op);
      next_last_result = last_result;
      if (op_valid_i) begin
         case (op_i)
            logical_shift_left_op, logical_shift_right_op, rotate_left_carry_op,
            rotate_right_carry_op, arith_shift_right_op, nibble_swap_op: begin
               // Swap shares the shifter's result path
               next_result = sh_result; // [RULE11]
               next_result_we = 1'b1;
            end
            transfer_flag_to_bit_op: begin
               // Other bits of the destination pass through untouched
               next_result = inserted; // [RULE14]
               next_result_we = 1'b1;
            end
            default: begin
               // Flag ops leave the register file alone
               next_result = result;
            end
         endcase
         if (next_result_we) begin
            next_last_result = next_result;
         end
      end
   end

   // Operation counter wraps; software clears it by writing
   // Clear beats a same-cycle increment, so software sees a clean zero
   always_comb begin
      next_op_count = op_count;
      if (bus_wr && wb_sel_i[0] && wb_adr_i == ADDR_OPCOUNT) begin
         next_op_count = 16'h0000;
      end else if (next_done) begin
         // Only real operations count; no_op and idle cycles do not
         next_op_count = op_count + 16'h0001;
      end
   end

   // Bus answer: ack one cycle after the request, read data with it;
   // unmapped addresses read zero and ignore writes.
   // Read data is captured at the request edge, so a flag op in the
   // same cycle shows up only on the next read
   always_comb begin
      next_ack = bus_req;
      next_rdata = rdata;
      if (bus_req && !wb_we_i) begin
         if (wb_adr_i == ADDR_STATUS) begin
            next_rdata = {24'h000000, status};
         end else if (wb_adr_i == ADDR_RESULT) begin
            next_rdata = {24'h000000, last_result};
         end else if (wb_adr_i == ADDR_OPCOUNT) begin
            next_rdata = {16'h0000, op_count};
         end else begin
            // Holes in the map read as zero
            next_rdata = 32'h00000000;
         end
      end
   end

   // State registers; every flag instruction lands in this one edge
   // Synchronous reset only; the whole unit leaves reset on one edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= STATUS_RESET;
         last_result <= RESULT_RESET;
         op_count <= 16'h0000;
         result <= RESULT_RESET;
         result_we <= 1'b0;
         done <= 1'b0;
         ack <= 1'b0;
         rdata <= 32'h00000000;
      end else begin
         status <= next_status;
         last_result <= next_last_result;
         op_count <= next_op_count;
         result <= next_result;
         result_we <= next_result_we;
         done <= next_done;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // Outputs straight from flip-flops
   // No logic after the registers, so the core sees clean timing
   assign result_o = result;
   assign result_we_o = result_we;
   assign done_o = done;
   assign status_o = status;
   assign irq_enable_o = status[FLAG_I];
   assign wb_dat_o = rdata;
   assign wb_ack_o = ack;

endmodule

// [verification/bit_shift_monitor.sv]
// Port-level checker for the bit, shift and flag unit
`timescale 1ns/1ps
module bit_shift_monitor import bit_shift_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Core side
   input wire logic op_valid_i,
   input wire bit_shift_pkg::op_e op_i,
   input wire logic [7:0] dest_i,
   input wire logic [7:0] src_i,
   input wire logic [2:0] bit_idx_i,
   input wire logic [7:0] result_o,
   input wire logic done_o,
   input wire logic [7:0] status_o,
   input wire logic irq_enable_o,
   // Bus write strobes
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i
);
   logic quiet; // No bus write competing for the status
   logic [7:0] ins_exp; // Destination with bit b taken from T
   assign quiet = !(wb_cyc_i && wb_stb_i && wb_we_i);
   // Bit insert reference
   always_comb begin
      ins_exp = dest_i;
      ins_exp[bit_idx_i] = status_o[FLAG_T];
   end
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // One operation taken with no bus write beside it
   sequence s_op(op_e o);
      op_valid_i && op_i == o && quiet;
   endsequence
   a_op_done: assert property (op_valid_i && op_i != no_op |=> done_o)
      else $error("done missing");
   a_irq_set: assert property (s_op(irq_flag_set_op) |=>
      status_o == ($past(status_o) | 8'h80))
      else $error("irq set wrong");
   a_irq_clear: assert property (s_op(irq_flag_clear_op) |=>
      status_o == ($past(status_o) & 8'h7F))
      else $error("irq clear wrong");
   a_irq_mirror: assert property (irq_enable_o == status_o[FLAG_I])
      else $error("irq enable mismatch");
   a_swap_nibbles: assert property (s_op(nibble_swap_op) |=>
      result_o == {$past(dest_i[3:0]), $past(dest_i[7:4])} && $stable(status_o))
      else $error("swap wrong");
   a_shift_left: assert property (s_op(logical_shift_left_op) |=>
      result_o == {$past(dest_i[6:0]), 1'b0} && status_o[FLAG_C] == $past(dest_i[7]))
      else $error("shift left wrong");
   a_asr_sign: assert property (s_op(arith_shift_right_op) |=>
      result_o == {$past(dest_i[7]), $past(dest_i[7:1])})
      else $error("arith shift wrong");
   a_bit_store: assert property (s_op(bit_to_transfer_flag_op) |=>
      status_o[FLAG_T] == $past(src_i[bit_idx_i]) &&
      {status_o[7], status_o[5:0]} == $past({status_o[7], status_o[5:0]}))
      else $error("bit store wrong");
   a_bit_load: assert property (s_op(transfer_flag_to_bit_op) |=>
      result_o == $past(ins_exp) && $stable(status_o))
      else $error("bit load wrong");
   a_generic_set: assert property (s_op(generic_flag_set_op) |=>
      status_o[$past(bit_idx_i)])
      else $error("generic set wrong");
endmodule

bind bit_shift_flag_instruction_unit bit_shift_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
   .op_valid_i(op_valid_i), .op_i(op_i), .dest_i(dest_i), .src_i(src_i),
   .bit_idx_i(bit_idx_i), .result_o(result_o), .done_o(done_o), .status_o(status_o),
   .irq_enable_o(irq_enable_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i));

// [verification/reg_file_model.sv]
// Register file model holding the destination register
`timescale 1ns/1ps
module reg_file_model (
   // Clock and bench preload
   input wire logic clk_i,
   input wire logic load_i,
   input wire logic [7:0] load_val_i,
   // Write-back from the unit
   input wire logic result_we_i,
   input wire logic [7:0] result_i,
   // Operand to the unit
   output logic [7:0] dest_o
);
   logic [7:0] value; // Stored register
   // Preload wins over write-back
   always_ff @(posedge clk_i) begin
      if (load_i) begin
         value <= load_val_i;
      end else if (result_we_i) begin
         value <= result_i;
      end
   end
   // Forwarding, so back-to-back ops see the fresh result
   assign dest_o = result_we_i ? result_i : value;
endmodule

// [verification/tb.sv]
// Self-checking bench for the bit, shift and flag unit
`timescale 1ns/1ps
module tb;
   import bit_shift_pkg::*;
   // Bench-driven inputs
   logic clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, load = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   op_e op_i = no_op;
   logic [7:0] src_i = 8'h00, load_val = 8'h00, wb_adr_i = 8'h00, dest, exp;
   logic [2:0] bit_idx_i = 3'h0;
   logic [3:0] wb_sel_i = 4'hF; // Only lane 0 matters
   logic [31:0] wb_dat_i = 32'h0, rd;
   // Unit outputs
   logic [7:0] result_o, status_o;
   logic result_we_o, done_o, irq_enable_o, wb_ack_o;
   logic [31:0] wb_dat_o;
   int n_mismatch = 0, n_checks = 0;
   // Dedicated flag ops and the bit each owns
   op_e set_ops [7] = '{carry_set_op, zero_set_op, negative_set_op, overflow_flag_set_op,
      sign_flag_set_op, transfer_flag_set_op, irq_flag_set_op};
   op_e clr_ops [7] = '{carry_clear_op, zero_clear_op, negative_clear_op,
      overflow_flag_clear_op, sign_flag_clear_op, transfer_flag_clear_op, irq_flag_clear_op};
   logic [7:0] masks [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80};

   bit_shift_flag_instruction_unit i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .op_valid_i(op_valid_i), .op_i(op_i), .dest_i(dest), .src_i(src_i),
      .bit_idx_i(bit_idx_i), .result_o(result_o), .result_we_o(result_we_o),
      .done_o(done_o), .status_o(status_o), .irq_enable_o(irq_enable_o),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   reg_file_model i_regs (.clk_i(clk_i), .load_i(load), .load_val_i(load_val),
      .result_we_i(result_we_o), .result_i(result_o), .dest_o(dest));

   // 25 MHz clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
      n_checks++;
      if (got !== e) begin
         $display("unexpected %s: expected %h, seen %h", name, e, got);
         n_mismatch++;
      end
   endtask

   // One operation, then a quiet cycle so it is taken exactly once;
   // outputs are looked at on the falling edge, where they have settled
   task automatic run(input op_e o, input logic [7:0] s, input logic [2:0] b,
      input logic we, input logic [7:0] res, input logic [7:0] st, input logic dn = 1'b1);
      op_valid_i <= 1'b1;
      op_i <= o;
      src_i <= s;
      bit_idx_i <= b;
      @(posedge clk_i);
      op_valid_i <= 1'b0;
      @(negedge clk_i);
      chk("done_o", {31'h0, dn}, {31'h0, done_o});
      chk("result_we_o", {31'h0, we}, {31'h0, result_we_o});
      if (we) chk("result_o", {24'h0, res}, {24'h0, result_o});
      chk("status_o", {24'h0, st}, {24'h0, status_o});
      @(posedge clk_i);
   endtask

   // Load the destination register; ops stop first
   task automatic preload(input logic [7:0] v);
      op_valid_i <= 1'b0;
      load <= 1'b1;
      load_val <= v;
      @(posedge clk_i);
      load <= 1'b0;
   endtask

   // Classic Wishbone cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      op_valid_i <= 1'b0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic final_report;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Hang guard, far beyond the roughly 150 cycles needed
   initial begin
      repeat (3000) @(posedge clk_i);
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("status_o", {24'h0, STATUS_RESET}, {24'h0, status_o});
      exp = 8'h00;
      for (int i = 0; i < 8; i++) begin
         exp[i] = 1'b1;
         run(generic_flag_set_op, 8'h00, 3'(i), 1'b0, 8'h00, exp);
      end
      chk("irq_enable_o", 32'h1, {31'h0, irq_enable_o});
      for (int i = 7; i >= 0; i--) begin
         exp[i] = 1'b0;
         run(generic_flag_clear_op, 8'h00, 3'(i), 1'b0, 8'h00, exp);
      end
      bus(1'b1, ADDR_STATUS, 32'h5A, rd);
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      chk("status read", 32'h5A, rd);
      // Index 5 is not theirs: dedicated ops must ignore it
      exp = 8'h5A;
      for (int k = 0; k < 7; k++) begin
         exp = exp | masks[k];
         run(set_ops[k], 8'h00, 3'h5, 1'b0, 8'h00, exp);
         exp = exp & ~masks[k];
         run(clr_ops[k], 8'h00, 3'h5, 1'b0, 8'h00, exp);
      end
      bus(1'b1, ADDR_STATUS, 32'h0, rd);
      preload(8'h81);
      run(carry_set_op, 8'h00, 3'h0, 1'b0, 8'h00, 8'h01);
      run(rotate_left_carry_op, 8'h00, 3'h0, 1'b1, 8'h03, 8'h09);
      run(rotate_right_carry_op, 8'h00, 3'h0, 1'b1, 8'h81, 8'h05);
      run(arith_shift_right_op, 8'h00, 3'h0, 1'b1, 8'hC0, 8'h05);
      run(logical_shift_right_op, 8'h00, 3'h0, 1'b1, 8'h60, 8'h00);
      run(logical_shift_left_op, 8'h00, 3'h0, 1'b1, 8'hC0, 8'h0C);
      run(logical_shift_left_op, 8'h00, 3'h0, 1'b1, 8'h80, 8'h05);
      run(nibble_swap_op, 8'h00, 3'h0, 1'b1, 8'h08, 8'h05);
      run(rotate_right_carry_op, 8'h00, 3'h0, 1'b1, 8'h84, 8'h0C);
      bus(1'b1, ADDR_STATUS, 32'h0, rd);
      preload(8'h01);
      run(bit_to_transfer_flag_op, 8'h20, 3'h5, 1'b0, 8'h00, 8'h40);
      run(transfer_flag_to_bit_op, 8'h00, 3'h7, 1'b1, 8'h81, 8'h40);
      run(bit_to_transfer_flag_op, 8'hDF, 3'h5, 1'b0, 8'h00, 8'h00);
      run(transfer_flag_to_bit_op, 8'h00, 3'h0, 1'b1, 8'h80, 8'h00);
      run(logical_shift_left_op, 8'h00, 3'h0, 1'b1, 8'h00, 8'h0B);
      run(no_op, 8'h00, 3'h0, 1'b0, 8'h00, 8'h0B, 1'b0);
      // Lane 0 disabled: the status write must not land
      wb_sel_i <= 4'hE;
      bus(1'b1, ADDR_STATUS, 32'hFF, rd);
      wb_sel_i <= 4'hF;
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      chk("masked status write", 32'h0B, rd);
      // Read-only result and an unmapped place both shrug off writes
      bus(1'b1, ADDR_RESULT, 32'hFF, rd);
      bus(1'b0, ADDR_RESULT, 32'h0, rd);
      chk("result read", 32'h0, rd);
      bus(1'b1, 8'h0C, 32'hFF, rd);
      bus(1'b0, 8'h0C, 32'h0, rd);
      chk("unmapped read", 32'h0, rd);
      // 44 real operations so far; no_op must not count
      bus(1'b0, ADDR_OPCOUNT, 32'h0, rd);
      chk("op count", 32'h2C, rd);
      bus(1'b1, ADDR_OPCOUNT, 32'h0, rd);
      bus(1'b0, ADDR_OPCOUNT, 32'h0, rd);
      chk("op count cleared", 32'h0, rd);
      final_report();
   end
endmodule
